// ### rtl/als_ctrl.sv
// Light sensor control: conversion sequencer, ranging, window alert, bus timeout, APB registers
`timescale 1ns/1ps
module als_ctrl #(
    parameter int unsigned T100_CYC  = als_pkg::T_SHORT_MS * als_pkg::CLK_KHZ,
    parameter int unsigned T800_CYC  = als_pkg::T_LONG_MS * als_pkg::CLK_KHZ,
    parameter int unsigned TRDY_CYC  = als_pkg::T_READY_MS * als_pkg::CLK_KHZ,
    parameter int unsigned TIMEO_CYC = als_pkg::T_TIMEO_MS * als_pkg::CLK_KHZ
) (
    input  wire logic             ref_clk_i,
    input  wire logic             rstn_i,
    input  wire als_pkg::apb_req_t apb_i,
    output als_pkg::apb_rsp_t     apb_o,
    input  wire logic [22:0]      light_raw_i,
    input  wire logic             scl_i,
    input  wire logic [1:0]       addr_sel_i,
    output logic                  int_o,
    output logic                  int_oe_o,
    output logic                  bus_rst_o,
    output logic [6:0]            slave_addr_o,
    output logic                  conv_active_o
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        als_pkg::conv_st_t st;     // Sequencer state
        logic [31:0]       cnt;    // Conversion cycle counter
        logic [31:0]       tgt;    // Cycles of this conversion
        logic [31:0]       tcnt;   // SCL low counter
        logic              bus_rst;
        logic [6:0]        saddr;
        logic [3:0]        rng;    // Full scale range select
        logic              tlong;  // Long conversion time select
        logic              conv;   // Converting, registered for the output
        logic [1:0]        mode;
        logic              latch;
        logic              pol;
        logic [1:0]        fc;
        logic              rdy;
        logic              fh;
        logic              fl;
        logic [3:0]        hcnt;   // Consecutive above-high results
        logic [3:0]        lcnt;   // Consecutive below-low results
        logic [15:0]       low;
        logic [15:0]       high;
        logic [15:0]       result;
        logic              int_oe;
        als_pkg::apb_rsp_t rsp;
    } state_t;

    state_t s_q;
    state_t s_d;

    // Exponent and mantissa to linear count
    function automatic logic [26:0] to_lin(input logic [15:0] v);
        return 27'(v[11:0]) << v[15:12];
    endfunction

    // Raw count to exponent and mantissa
    function automatic logic [15:0] encode(input logic [22:0] raw, input logic [3:0] rng);
        logic [3:0]  e;
        logic [22:0] sh;
        e = (rng > als_pkg::EXP_MAX) ? als_pkg::EXP_MAX : rng;
        if (rng == als_pkg::RANGE_AUTO) begin
            // Smallest range that keeps the mantissa unsaturated
            e = 4'h0;
            for (int i = 0; i < int'(als_pkg::EXP_MAX); i++) begin
                if ((raw >> i) > als_pkg::MANT_MAX) begin
                    e = 4'(i + 1);
                end
            end
        end
        sh = raw >> e;
        // Fixed range too small for the light: clip to full scale
        return {e, (sh > als_pkg::MANT_MAX) ? 12'hFFF : sh[11:0]};
    endfunction

    // Consecutive faults needed: 1, 2, 4 or 8
    function automatic logic [3:0] need(input logic [1:0] fc);
        return 4'h1 << fc;
    endfunction

    logic        done;
    logic [15:0] res_n;
    logic        above;
    logic        below;
    logic        rd_acc;
    logic        wr_acc;
    logic [15:0] cfg_rd;

    assign done   = (s_q.st == als_pkg::ST_CONV) && (s_q.cnt == s_q.tgt - 32'h1);
    assign res_n  = encode(light_raw_i, s_q.rng);
    assign above  = to_lin(res_n) > to_lin(s_q.high);
    assign below  = to_lin(res_n) < to_lin(s_q.low);
    assign rd_acc = apb_i.psel && apb_i.penable && s_q.rsp.pready && !apb_i.pwrite;
    assign wr_acc = apb_i.psel && apb_i.penable && s_q.rsp.pready && apb_i.pwrite;
    assign cfg_rd = {s_q.rng, s_q.tlong, s_q.mode, 1'b0, s_q.rdy, s_q.fh, s_q.fl,
                     s_q.latch, s_q.pol, 1'b0, s_q.fc};

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        s_d = s_q;
        s_d.bus_rst = 1'b0;
        // Strap sampled every cycle so a late strap still counts
        s_d.saddr = {als_pkg::ADDR_BASE, addr_sel_i};
        // SCL low watchdog; a high SCL rearms it
        if (scl_i) begin
            s_d.tcnt = 32'h0;
        end else if (s_q.tcnt == TIMEO_CYC - 32'h1) begin
            s_d.tcnt    = 32'h0;
            s_d.bus_rst = 1'b1;
        end else begin
            s_d.tcnt = s_q.tcnt + 32'h1;
        end

        // APB: one wait state, answer on the second access cycle
        s_d.rsp.pready  = apb_i.psel && apb_i.penable && !s_q.rsp.pready;
        s_d.rsp.pslverr = 1'b0;
        s_d.rsp.prdata  = 32'h0;
        if (s_d.rsp.pready) begin
            case (apb_i.paddr)
                als_pkg::OFS_RESULT: s_d.rsp.prdata = {16'h0, s_q.result};
                als_pkg::OFS_CONFIG: s_d.rsp.prdata = {16'h0, cfg_rd};
                als_pkg::OFS_LOW:    s_d.rsp.prdata = {16'h0, s_q.low};
                als_pkg::OFS_HIGH:   s_d.rsp.prdata = {16'h0, s_q.high};
                default:             s_d.rsp.pslverr = 1'b1;
            endcase
        end
        // Config read clears ready and, when latched, the flags
        if (rd_acc && apb_i.paddr == als_pkg::OFS_CONFIG) begin
            s_d.rdy = 1'b0;
            if (s_q.latch) begin
                s_d.fh = 1'b0;
                s_d.fl = 1'b0;
            end
        end
        if (wr_acc) begin
            case (apb_i.paddr)
                als_pkg::OFS_CONFIG: begin
                    s_d.rng   = apb_i.pwdata[als_pkg::CFG_RANGE +: 4];
                    s_d.tlong = apb_i.pwdata[als_pkg::CFG_LONG];
                    s_d.mode  = apb_i.pwdata[als_pkg::CFG_M +: 2];
                    s_d.latch = apb_i.pwdata[als_pkg::CFG_LAT];
                    s_d.pol   = apb_i.pwdata[als_pkg::CFG_POL];
                    s_d.fc    = apb_i.pwdata[als_pkg::CFG_FC +: 2];
                end
                als_pkg::OFS_LOW:  s_d.low  = apb_i.pwdata[15:0];
                als_pkg::OFS_HIGH: s_d.high = apb_i.pwdata[15:0];
                default: ;
            endcase
        end

        // Conversion sequencer
        case (s_q.st)
            als_pkg::ST_SHUT: begin
                // Leaves shutdown only on a commanded mode
                if (s_d.mode != als_pkg::M_SHUT) begin
                    s_d.st  = als_pkg::ST_CONV;
                    s_d.cnt = 32'h0;
                    // Integration plus settling time
                    s_d.tgt = (s_d.tlong ? T800_CYC : T100_CYC) + TRDY_CYC;
                end
            end
            als_pkg::ST_CONV: begin
                if (s_d.mode == als_pkg::M_SHUT) begin
                    // Abort on a shutdown command
                    s_d.st = als_pkg::ST_SHUT;
                end else if (done) begin
                    s_d.result = res_n;
                    s_d.rdy    = 1'b1;
                    // Fault counters restart on any other outcome
                    s_d.hcnt = !above ? 4'h0 : (s_q.hcnt == als_pkg::FCNT_SAT) ? s_q.hcnt : s_q.hcnt + 4'h1;
                    s_d.lcnt = !below ? 4'h0 : (s_q.lcnt == als_pkg::FCNT_SAT) ? s_q.lcnt : s_q.lcnt + 4'h1;
                    if (s_d.hcnt >= need(s_q.fc)) begin
                        s_d.fh = 1'b1;
                        if (!s_q.latch) begin
                            s_d.fl = 1'b0;
                        end
                    end
                    if (s_d.lcnt >= need(s_q.fc)) begin
                        s_d.fl = 1'b1;
                        if (!s_q.latch) begin
                            s_d.fh = 1'b0;
                        end
                    end
                    if (s_q.mode == als_pkg::M_SINGLE) begin
                        s_d.mode = als_pkg::M_SHUT;
                        s_d.st   = als_pkg::ST_SHUT;
                    end else begin
                        s_d.cnt = 32'h0;
                        s_d.tgt = (s_d.tlong ? T800_CYC : T100_CYC) + TRDY_CYC;
                    end
                end else begin
                    s_d.cnt = s_q.cnt + 32'h1;
                end
            end
            default: s_d.st = als_pkg::ST_SHUT;
        endcase
        // Open drain: enable pulls low; polarity picks which state pulls
        s_d.int_oe = (s_d.fh || s_d.fl) ^ s_d.pol;
        // Activity flag kept in a flop so the output has no logic after it
        s_d.conv = (s_d.st == als_pkg::ST_CONV);
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_q        <= '0;
            s_q.st     <= als_pkg::ST_SHUT;
            s_q.tgt    <= 32'h1;
            s_q.rng    <= als_pkg::CFG_RST[als_pkg::CFG_RANGE +: 4];
            s_q.tlong  <= als_pkg::CFG_RST[als_pkg::CFG_LONG];
            s_q.latch  <= als_pkg::CFG_RST[als_pkg::CFG_LAT];
            s_q.low    <= als_pkg::LOW_RST;
            s_q.high   <= als_pkg::HIGH_RST;
            s_q.saddr  <= {als_pkg::ADDR_BASE, 2'h0};
        end else begin
            s_q <= s_d;
        end
    end

    assign apb_o         = s_q.rsp;
    assign int_o         = 1'b0;
    assign int_oe_o      = s_q.int_oe;
    assign bus_rst_o     = s_q.bus_rst;
    assign slave_addr_o  = s_q.saddr;
    assign conv_active_o = s_q.conv;

    // ****************************************
    // Checks
    // ****************************************
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    a_shut_holds: assert property ((s_q.st == als_pkg::ST_SHUT && s_d.mode == als_pkg::M_SHUT) |=> s_q.st == als_pkg::ST_SHUT) else $error("conversion started in shutdown");
    a_conv_len: assert property ($rose(conv_active_o) |-> s_q.tgt == (s_q.tlong ? T800_CYC : T100_CYC) + TRDY_CYC) else $error("wrong conversion length");
    a_long_time: assert property (($rose(conv_active_o) && s_q.tlong) |-> s_q.tgt == T800_CYC + TRDY_CYC) else $error("long time not used");
    a_ready_set: assert property ((done && s_d.mode != als_pkg::M_SHUT) |=> s_q.rdy && s_q.result == $past(res_n)) else $error("result not ready at end");
    a_auto_range: assert property ((done && s_q.rng == als_pkg::RANGE_AUTO) |-> (res_n[15:12] == 4'h0 || res_n[11])) else $error("auto range not optimal");
    a_single_stop: assert property ((done && s_q.mode == als_pkg::M_SINGLE && !wr_acc) |=> s_q.st == als_pkg::ST_SHUT && s_q.mode == als_pkg::M_SHUT) else $error("single shot kept running");
    a_cont_again: assert property ((done && s_q.mode[1] && !wr_acc) |=> conv_active_o && s_q.cnt == 32'h0) else $error("continuous mode stopped");
    a_timeout_rst: assert property ((!scl_i && s_q.tcnt == TIMEO_CYC - 32'h1) |=> bus_rst_o ##1 !bus_rst_o) else $error("no bus reset after timeout");
    a_fault_need: assert property ($rose(s_q.fh) |-> s_q.hcnt >= need(s_q.fc)) else $error("alert before fault count");
    a_alert_pin: assert property (int_oe_o == ((s_q.fh || s_q.fl) ^ s_q.pol)) else $error("alert pin disagrees with flags");
    a_addr_map: assert property (##1 slave_addr_o == {als_pkg::ADDR_BASE, $past(addr_sel_i)}) else $error("bad slave address");
endmodule

// ### rtl/als_pkg.sv
// Package: constants, register map and carrier types of the light sensor control block
// Overview of operation
// - Reset serial bus logic after SCL low 28 ms
// - Integrate over 100 ms or 800 ms
// - Conversion time bit 1 selects 800 ms
// - Range select 1100b means automatic range
// - Auto range picks best range every measurement
// - Continuous and single-shot modes, chosen by command
// - Start in shutdown, convert only when commanded
// - Lux result readable by the host
// - Window comparison drives the alert pin
// - Data ready 3 ms after integration ends
// - Slave address from four-way strap pin
// - Alert only after N consecutive same faults
package als_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam int unsigned CLK_KHZ    = 250000; // Reference clock rate
    localparam int unsigned T_SHORT_MS = 100;    // Short integration
    localparam int unsigned T_LONG_MS  = 800;    // Long integration
    localparam int unsigned T_READY_MS = 3;      // Settling after integration
    localparam int unsigned T_TIMEO_MS = 28;     // Bus timeout period
    // ****************************************
    // Register map, byte addresses
    // ****************************************
    localparam logic [7:0] OFS_RESULT = 8'h00;
    localparam logic [7:0] OFS_CONFIG = 8'h04;
    localparam logic [7:0] OFS_LOW    = 8'h08;
    localparam logic [7:0] OFS_HIGH   = 8'h0C;
    // Configuration fields
    localparam int CFG_RANGE = 12; // Range select, 4 bits
    localparam int CFG_LONG  = 11; // Conversion time select
    localparam int CFG_M   = 9;  // Mode, 2 bits
    localparam int CFG_RDY = 7;  // Conversion ready
    localparam int CFG_FH  = 6;  // Flag high
    localparam int CFG_FL  = 5;  // Flag low
    localparam int CFG_LAT = 4;  // Latched window
    localparam int CFG_POL = 3;  // Alert polarity
    localparam int CFG_FC  = 0;  // Fault count, 2 bits
    localparam logic [15:0] CFG_RST  = 16'hC810;
    localparam logic [15:0] LOW_RST  = 16'h0000;
    localparam logic [15:0] HIGH_RST = 16'hBFFF;
    // ****************************************
    // Codes
    // ****************************************
    localparam logic [3:0]  RANGE_AUTO = 4'hC;
    localparam logic [3:0]  EXP_MAX  = 4'hB;
    localparam logic [22:0] MANT_MAX = 23'h000FFF;
    localparam logic [1:0]  M_SHUT   = 2'h0;
    localparam logic [1:0]  M_SINGLE = 2'h1;
    localparam logic [4:0]  ADDR_BASE = 5'h11;
    localparam logic [3:0]  FCNT_SAT  = 4'h8;
    typedef enum logic [1:0] {ST_SHUT = 2'h1, ST_CONV = 2'h2} conv_st_t;
    // APB request and answer
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_t;
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_t;
endpackage

// ### testbench/scl_master_model.sv
// Bus master stand-in: paces the serial clock, or parks it low on command
`timescale 1ns/1ps
module scl_master_model (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    input  wire logic hold_low_i,
    output logic      scl_o
);
    // Divider keeps the serial clock far slower than the reference clock
    logic [1:0] div_q;
    // ****************************************
    // Serial clock generation
    // ****************************************
    // Toggle on each divider wrap; a hold mimics a master stuck mid-frame
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div_q <= 2'h0;
            scl_o <= 1'b1;
        end else begin
            div_q <= div_q + 2'h1;
            if (hold_low_i) begin
                scl_o <= 1'b0;
            end else if (div_q == 2'h3) begin
                scl_o <= ~scl_o;
            end
        end
    end
endmodule

// ### testbench/tb.sv
// Self-checking bench of the light sensor control block
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin checks_done++; if ((got) !== (exp)) begin mismatches++; $display("CHECK FAILED %0t %s", $time, msg); end end
module tb;
    // ****************************************
    // Shortened counts keep the run brief
    // ****************************************
    localparam int T100  = 200;
    localparam int T800  = 1600;
    localparam int TRDY  = 6;
    localparam int TIMEO = 56;
    logic              ref_clk_i, rstn_i, scl_hold_q, scl, int_o, int_oe, bus_rst, conv_active, err;
    als_pkg::apb_req_t apb_q;
    als_pkg::apb_rsp_t apb_rsp;
    logic [22:0]       light_q;
    logic [1:0]        addr_sel_q;
    logic [6:0]        slave_addr;
    logic [31:0]       rd;
    int                mismatches, checks_done;
    // Reference clock, 4 ns period
    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    als_ctrl #(.T100_CYC(T100), .T800_CYC(T800), .TRDY_CYC(TRDY), .TIMEO_CYC(TIMEO)) dut_u (
        .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .apb_i(apb_q), .apb_o(apb_rsp), .light_raw_i(light_q),
        .scl_i(scl), .addr_sel_i(addr_sel_q), .int_o(int_o), .int_oe_o(int_oe), .bus_rst_o(bus_rst),
        .slave_addr_o(slave_addr), .conv_active_o(conv_active));
    scl_master_model host_u (.clk_i(ref_clk_i), .rstn_i(rstn_i), .hold_low_i(scl_hold_q), .scl_o(scl));
    // One APB transfer; the request is held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        int n;
        n = 0;
        apb_q <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
        @(posedge ref_clk_i);
        apb_q.penable <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 20);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        `CHK(n < 20, 1'b1, "apb answer missing")
        apb_q <= '0;
        @(posedge ref_clk_i);
    endtask
    // Cycles spent converting, with bounded waits on both ends
    task automatic conv_len(output int n);
        int g;
        n = 0;
        g = 0;
        while (conv_active !== 1'b1 && g < 50) begin
            @(posedge ref_clk_i);
            g++;
        end
        while (conv_active === 1'b1 && n < 4000) begin
            @(posedge ref_clk_i);
            n++;
        end
    endtask
    // Power-up state, strap decoding and an unmapped access
    task automatic t_reset();
        `CHK(conv_active, 1'b0, "active after reset")
        `CHK(int_oe, 1'b0, "alert after reset")
        `CHK(int_o, 1'b0, "open drain data not low")
        apb(1'b0, als_pkg::OFS_CONFIG, 32'h0);
        `CHK(rd, 32'h0000C810, "config reset value")
        apb(1'b0, 8'h10, 32'h0);
        `CHK(err, 1'b1, "unmapped not refused")
        for (int i = 0; i < 4; i++) begin
            addr_sel_q <= i[1:0];
            repeat (3) @(posedge ref_clk_i);
            `CHK(slave_addr, {5'h11, i[1:0]}, "slave address")
        end
    endtask
    // One single-shot conversion: length, result and return to shutdown
    task automatic t_single(input logic lng, input logic [3:0] rng, input logic [22:0] raw,
                            input logic [15:0] res, input int tgt);
        int n;
        light_q <= raw;
        apb(1'b1, als_pkg::OFS_CONFIG, {16'h0, rng, lng, 2'b01, 9'h010});
        conv_len(n);
        `CHK(n >= tgt && n <= tgt + 2, 1'b1, "conversion length")
        apb(1'b0, als_pkg::OFS_RESULT, 32'h0);
        `CHK(rd, {16'h0, res}, "result word")
        apb(1'b0, als_pkg::OFS_CONFIG, 32'h0);
        `CHK({rd[10:9], rd[7]}, 3'b001, "mode back to shutdown, ready set")
        repeat (20) @(posedge ref_clk_i);
        `CHK(conv_active, 1'b0, "restarted after single shot")
    endtask
    // Continuous run, two-hit fault count, polarity and latched flag clear
    task automatic t_window();
        light_q <= 23'h000200;
        apb(1'b1, als_pkg::OFS_HIGH, 32'h00000100);
        apb(1'b1, als_pkg::OFS_CONFIG, 32'h00000611);
        repeat (309) @(posedge ref_clk_i);
        `CHK(int_oe, 1'b0, "alert after one hit")
        `CHK(conv_active, 1'b1, "continuous stopped")
        repeat (206) @(posedge ref_clk_i);
        `CHK(int_oe, 1'b1, "alert after two hits")
        apb(1'b1, als_pkg::OFS_CONFIG, 32'h00000019);
        repeat (3) @(posedge ref_clk_i);
        `CHK(int_oe, 1'b0, "polarity not applied")
        `CHK(conv_active, 1'b0, "stop not honoured")
        apb(1'b0, als_pkg::OFS_CONFIG, 32'h0);
        `CHK(rd[6:5], 2'b10, "flag high")
        repeat (3) @(posedge ref_clk_i);
        `CHK(int_oe, 1'b1, "latched flag not cleared by read")
    endtask
    // Serial clock parked low resets the bus logic; a running clock never does
    task automatic t_timeout();
        int n;
        int pulses;
        n = 0;
        pulses = 0;
        repeat (3 * TIMEO) begin
            @(posedge ref_clk_i);
            pulses += (bus_rst === 1'b1);
        end
        `CHK(pulses, 0, "reset while clock runs")
        // Park only from a high clock so no earlier low time counts
        for (int k = 0; k < 8 && scl !== 1'b1; k++) begin
            @(posedge ref_clk_i);
        end
        scl_hold_q <= 1'b1;
        while (bus_rst !== 1'b1 && n < 4 * TIMEO) begin
            @(posedge ref_clk_i);
            n++;
        end
        `CHK(n >= TIMEO && n <= TIMEO + 3, 1'b1, "timeout length")
        scl_hold_q <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    // Closing: counts, verdict, end of run
    task automatic end_sim();
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        rstn_i = 1'b0;
        apb_q = '0;
        light_q = '0;
        addr_sel_q = 2'h0;
        scl_hold_q = 1'b0;
        mismatches = 0;
        checks_done = 0;
        repeat (2) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        @(posedge ref_clk_i);
        t_reset();
        t_single(1'b0, 4'h0, 23'h000123, 16'h0123, T100 + TRDY);
        t_single(1'b1, 4'h0, 23'h000123, 16'h0123, T800 + TRDY);
        t_single(1'b0, 4'h3, 23'h012345, 16'h3FFF, T100 + TRDY);
        t_single(1'b0, 4'hC, 23'h012345, 16'h591A, T100 + TRDY);
        t_window();
        t_timeout();
        end_sim();
    end
    // Watchdog well beyond the expected run
    initial begin
        repeat (60000) @(posedge ref_clk_i);
        mismatches++;
        end_sim();
    end
endmodule
